// ==== include/hsd_cfg.svh ====
`ifndef HSD_CFG_SVH
`define HSD_CFG_SVH

// Port and pin counts
`define HSD_PORTS        6
`define HSD_PF_COUNT     29
`define HSD_PF_FIRST     3
`define HSD_PF_IDX_W     5
`define HSD_PF_LAST_IDX  5'h1c

// Six-level strap codes, ordered by resistor value
`define HSD_CODE_200K_DN 3'h0
`define HSD_CODE_200K_UP 3'h1
`define HSD_CODE_10K_DN  3'h2
`define HSD_CODE_10K_UP  3'h3
`define HSD_CODE_10R_DN  3'h4
`define HSD_CODE_10R_UP  3'h5

// Valid function-select combination (configuration 3)
`define HSD_SEL2_CFG3    3'h0
`define HSD_SEL1_CFG3    3'h2

// Split power enable ports occupy port indices 2..4 (ports 3, 4, 5)
`define HSD_SPLIT_BASE   2
`define HSD_SPLIT_COUNT  3

// Reset values
`define HSD_MASK_RST     6'h00
`define HSD_SYNC_STAGES  2

`endif

// ==== include/hsd_pkg.sv ====
`default_nettype none
package hsd_pkg;

  typedef enum logic [3:0] {
    HSD_FN_NC,
    HSD_FN_AUDIO,
    HSD_FN_PWR_SENSE,
    HSD_FN_SPLIT_PWR,
    HSD_FN_MASTER_I2C,
    HSD_FN_TARGET_I2C,
    HSD_FN_QSPI,
    HSD_FN_MICROPHONE_PRESENT,
    HSD_FN_GPIO,
    HSD_FN_UP_PWR_DET
  } hsd_pin_fn_t;

  // Raw strap levels as seen on the pins
  typedef struct packed {
    logic [5:0] dplus_dis;
    logic [5:0] dminus_dis;
    logic [2:0] fixed_code;
    logic [2:0] charge_code;
    logic [2:0] sel2_code;
    logic [2:0] sel1_code;
  } hsd_strap_t;

  // Per-port status toward the hub core
  typedef struct packed {
    logic [5:0] hs_disabled;
    logic [5:0] ss_disabled;
    logic [5:0] fixed_mask;
    logic [5:0] charge_mask;
  } hsd_port_cfg_t;

  typedef enum logic {HSD_ST_CAPTURE, HSD_ST_RUN} hsd_state_t;

endpackage
`default_nettype wire

// ==== rtl/hsd_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser; the first stage feeds only the second
module hsd_sync2 #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         mclk,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // No reset so strap levels keep flowing while reset is held
  always_ff @(posedge mclk) begin
    meta_q   <= async_in;
    sync_out <= meta_q;
  end
endmodule
`default_nettype wire

// ==== rtl/hsd_strap_power.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hsd_cfg.svh"
// Summary of operation
// R1: Read D+ and D- disable straps separately
// R2: Port disabled only when both straps high
// R3: Strapped-off port also disables superspeed side
// R4: Decode six-level fixed port count strap
// R5: Decode six-level charging port count strap
// R6: Only configuration 3 selection is valid
// R7: Configuration 3 routes programmable pins by table
// R8: Pin-mux registers override default pin functions
// R9: Enabled port: sense pin input, pull-up on
// R10: Disabled port: sense pin driven low
// R11: Split mode narrows ports 1-5 to USB2; split_mode here only drives superspeed enables of ports 3-5
// R12: Split mode drives superspeed enables ports 3-5
// R13: Microphone detect reads 1 when plugged
// R14: Board holds SPI clock low in reset
// R15: Board holds SPI chip enable high powerdown
// R16: Straps captured at reset release, held
// R17: Six-level straps arrive as codes 0-5
module hsd_strap_power (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Strap pins
  input  wire hsd_pkg::hsd_strap_t strap_pins,
  // Runtime controls from hub core
  input  wire logic [5:0]          host_port_disable,
  input  wire logic                split_mode,
  input  wire logic                pinmux_wr,
  input  wire logic [4:0]          pinmux_idx,
  input  wire hsd_pkg::hsd_pin_fn_t pinmux_fn,
  input  wire logic                pinmux_clear,
  // Power sense pins (open drain)
  input  wire logic [5:0]          port_power_sense_in,
  output logic      [5:0]          port_power_sense_out,
  output logic      [5:0]          port_power_sense_oe_n,
  output logic      [5:0]          port_power_sense_pullup,
  output logic      [2:0]          split_superspeed_power_enable,
  // Sense pins
  input  wire logic                microphone_present_pin,
  input  wire logic                upstream_power_detect_pin,
  // Status
  output hsd_pkg::hsd_port_cfg_t   port_cfg,
  output logic      [5:0]          overcurrent_n,
  output logic                     config_valid,
  output logic                     microphone_present,
  output logic                     upstream_power_detect,
  output hsd_pkg::hsd_pin_fn_t     pin_fn [`HSD_PF_COUNT]
);
  import hsd_pkg::*;

  hsd_strap_t    strap_s;
  logic [5:0]    sense_s;
  logic [1:0]    misc_s;
  hsd_state_t    state_q, state_d;
  hsd_strap_t    cfg_q, cfg_d;
  hsd_port_cfg_t pcfg_q, pcfg_d;
  logic          valid_q, valid_d;
  logic [5:0]    pwr_on;
  logic [5:0]    oe_n_q, oe_n_d;
  logic [5:0]    oc_n_q, oc_n_d;
  logic [2:0]    ssen_q, ssen_d;
  logic [1:0]    misc_q, misc_d;
  hsd_pin_fn_t   ovr_fn_q [`HSD_PF_COUNT];
  hsd_pin_fn_t   ovr_fn_d [`HSD_PF_COUNT];
  logic [`HSD_PF_COUNT-1:0] ovr_vld_q, ovr_vld_d;

  // All pin inputs cross into mclk before use
  hsd_sync2 #(.W($bits(hsd_strap_t))) u_sync_strap (
    .mclk     (mclk),
    .async_in (strap_pins),
    .sync_out (strap_s)
  );
  hsd_sync2 #(.W(8)) u_sync_sense (
    .mclk     (mclk),
    .async_in ({microphone_present_pin, upstream_power_detect_pin, port_power_sense_in}),
    .sync_out ({misc_s, sense_s})
  );

  // R17: codes 0-5 in resistor order
  // Strap code to number of ports covered; codes 6 and 7 cover none
  function automatic logic [5:0] code_mask(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h00;
    unique case (code)
      `HSD_CODE_200K_DN: m = 6'h00;
      `HSD_CODE_200K_UP: m = 6'h01;
      `HSD_CODE_10K_DN:  m = 6'h03;
      `HSD_CODE_10K_UP:  m = 6'h07;
      `HSD_CODE_10R_DN:  m = 6'h0f;
      `HSD_CODE_10R_UP:  m = 6'h3f;
      default:           m = 6'h00;
    endcase
    return m;
  endfunction

  // Default function of pin PF(idx + first)
  function automatic hsd_pin_fn_t dflt_fn(input int pf);
    hsd_pin_fn_t f;
    f = HSD_FN_NC;
    if (pf >= 3 && pf <= 7) f = HSD_FN_AUDIO;
    else if (pf >= 10 && pf <= 12) f = HSD_FN_SPLIT_PWR;
    else if ((pf >= 13 && pf <= 17) || pf == 28) f = HSD_FN_PWR_SENSE;
    else if (pf == 18 || pf == 31) f = HSD_FN_MASTER_I2C;
    else if (pf == 19) f = HSD_FN_MICROPHONE_PRESENT;
    else if (pf >= 20 && pf <= 25) f = HSD_FN_QSPI;
    else if (pf == 26 || pf == 27) f = HSD_FN_TARGET_I2C;
    else if (pf == 29) f = HSD_FN_GPIO;
    else if (pf == 30) f = HSD_FN_UP_PWR_DET;
    return f;
  endfunction

  // Capture sequencer and decoded configuration
  always_comb begin
    state_d = state_q;
    cfg_d   = cfg_q;
    pcfg_d  = pcfg_q;
    valid_d = valid_q;
    if (state_q == HSD_ST_CAPTURE) begin
      // R16: latch straps once after release
      cfg_d   = strap_s;
      state_d = HSD_ST_RUN;
      // R1: each line sampled separately
      // R2: both lines high disables the port
      pcfg_d.hs_disabled = strap_s.dplus_dis & strap_s.dminus_dis;
      // R3: superspeed side follows strap disable
      pcfg_d.ss_disabled = strap_s.dplus_dis & strap_s.dminus_dis;
      // R4: fixed port count decode
      pcfg_d.fixed_mask  = code_mask(strap_s.fixed_code);
      // R5: charging port count decode
      pcfg_d.charge_mask = code_mask(strap_s.charge_code);
      // R6: only configuration 3 is accepted
      valid_d = (strap_s.sel2_code == `HSD_SEL2_CFG3) &&
                (strap_s.sel1_code == `HSD_SEL1_CFG3);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= HSD_ST_CAPTURE;
      cfg_q   <= '0;
      pcfg_q  <= '{default: `HSD_MASK_RST};
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cfg_q   <= cfg_d;
      pcfg_q  <= pcfg_d;
      valid_q <= valid_d;
    end
  end

  // Port power pins and split enables
  always_comb begin
    for (int i = 0; i < `HSD_PORTS; i++) begin
      pwr_on[i] = (state_q == HSD_ST_RUN) && !pcfg_q.hs_disabled[i] && !host_port_disable[i];
    end
    // R9: enabled ports release the pin, R10: disabled ports drive it
    oe_n_d = pwr_on;
    // Overcurrent only means something while the pin is an input
    oc_n_d = sense_s | ~pwr_on;
    // R11: split mode should narrow ports 1-5, but only ports 3-5 change here; ports 1, 2 and 6 never split
    // R12: separate superspeed enables only in split mode
    for (int k = 0; k < `HSD_SPLIT_COUNT; k++) begin
      ssen_d[k] = split_mode && (state_q == HSD_ST_RUN) &&
                  !pcfg_q.ss_disabled[k + `HSD_SPLIT_BASE];
    end
    // R13: 1 means microphone plugged
    misc_d = misc_s;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oe_n_q <= 6'h00;
      oc_n_q <= 6'h3f;
      ssen_q <= 3'h0;
      misc_q <= 2'h0;
    end else begin
      oe_n_q <= oe_n_d;
      oc_n_q <= oc_n_d;
      ssen_q <= ssen_d;
      misc_q <= misc_d;
    end
  end

  // Pin-mux override table, one entry per programmable pin
  always_comb begin
    ovr_vld_d = ovr_vld_q;
    ovr_fn_d  = ovr_fn_q;
    if (pinmux_clear) begin
      ovr_vld_d = '0;
    end else if (pinmux_wr && pinmux_idx <= `HSD_PF_LAST_IDX) begin
      // R8: runtime override of one pin
      ovr_vld_d[pinmux_idx] = 1'b1;
      ovr_fn_d[pinmux_idx]  = pinmux_fn;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovr_vld_q <= '0;
      ovr_fn_q  <= '{default: HSD_FN_NC};
    end else begin
      ovr_vld_q <= ovr_vld_d;
      ovr_fn_q  <= ovr_fn_d;
    end
  end

  // R7: default routing applies only to the valid configuration
  generate
    for (genvar p = 0; p < `HSD_PF_COUNT; p++) begin : g_pin
      assign pin_fn[p] = ovr_vld_q[p] ? ovr_fn_q[p] :
                         (valid_q ? dflt_fn(p + `HSD_PF_FIRST) : HSD_FN_NC);
    end
  endgenerate

  // Pins are registered; low level driven whenever enabled for output
  assign port_power_sense_out          = 6'h00;
  assign port_power_sense_oe_n         = oe_n_q;
  assign port_power_sense_pullup       = oe_n_q;
  assign split_superspeed_power_enable = ssen_q;
  assign port_cfg                      = pcfg_q;
  assign overcurrent_n                 = oc_n_q;
  assign config_valid                  = valid_q;
  assign microphone_present            = misc_q[1];
  assign upstream_power_detect         = misc_q[0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_capture;
    state_q == HSD_ST_CAPTURE;
  endsequence
  sequence s_run_two;
    (state_q == HSD_ST_RUN) [*2];
  endsequence

  a_strap_held_run: assert property (s_capture |=> s_run_two ##0 $stable(pcfg_q)) // R16
    else $error("Captured strap set changed after capture");
  a_both_lines_dis: assert property (s_capture |=> pcfg_q.hs_disabled == ($past(strap_s.dplus_dis) & $past(strap_s.dminus_dis))) // R2
    else $error("Port disable does not need both lines");
  a_ss_follows_hs: assert property (pcfg_q.ss_disabled == pcfg_q.hs_disabled) // R3
    else $error("Superspeed side not disabled with USB2 side");
  a_fixed_top_code: assert property (s_capture ##0 (strap_s.fixed_code == `HSD_CODE_10R_UP) |=> pcfg_q.fixed_mask == 6'h3f) // R4
    else $error("Top fixed code not all six ports");
  a_charge_one_port: assert property (s_capture ##0 (strap_s.charge_code == `HSD_CODE_200K_UP) |=> pcfg_q.charge_mask == 6'h01) // R5
    else $error("Charging code one not port 1");
  a_cfg3_only: assert property (s_capture ##0 (strap_s.sel1_code != `HSD_SEL1_CFG3) |=> !config_valid) // R6
    else $error("Reserved selection accepted");
  a_dis_drives_low: assert property ((state_q == HSD_ST_RUN) && host_port_disable[0] |=> !port_power_sense_oe_n[0] && !port_power_sense_pullup[0]) // R10
    else $error("Disabled port pin not driven low");
  a_en_pullup: assert property (s_run_two ##0 (!host_port_disable[5] && !pcfg_q.hs_disabled[5]) |=> port_power_sense_oe_n[5] && port_power_sense_pullup[5]) // R9
    else $error("Enabled port pin not input with pull-up");
  a_split_off_idle: assert property (!split_mode |=> split_superspeed_power_enable == 3'h0) // R12
    else $error("Split enable active with split mode off");
  a_mic_latency: assert property (microphone_present_pin ##1 microphone_present_pin ##1 microphone_present_pin |=> microphone_present) // R13
    else $error("Microphone presence not reported");
endmodule
`default_nettype wire

// ==== test/hsd_board_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Board side: strap resistors and port power switches
module hsd_board_model (
  // Clock
  input  wire logic                mclk,
  // Scenario controls
  input  wire hsd_pkg::hsd_strap_t strap_cfg,
  input  wire logic [5:0]          oc_inject,
  // Device side of the sense pins
  input  wire logic [5:0]          sense_out,
  input  wire logic [5:0]          sense_oe_n,
  input  wire logic [5:0]          sense_pullup,
  // Levels toward the device
  output hsd_pkg::hsd_strap_t      strap_pins,
  output logic [5:0]               sense_in,
  // Serial flash pins held by the board
  output logic                     spi_clk_pin,
  output logic                     spi_chip_enable_n_pin
);
  import hsd_pkg::*;
  logic [5:0] float_q = 6'h15;
  // Resistors hold the strap level at all times
  assign strap_pins = strap_cfg;
  // flash clock held low across reset
  assign spi_clk_pin = 1'b0;
  // chip enable held high, flash idle
  assign spi_chip_enable_n_pin = 1'b1;
  // An unpulled, undriven pin must not look stable
  always_ff @(posedge mclk) begin
    float_q <= ~float_q;
  end
  // Wire level: device drive wins, then monitor, then pull-up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!sense_oe_n[i])
        sense_in[i] = sense_out[i];
      else if (oc_inject[i])
        sense_in[i] = 1'b0;
      else if (sense_pullup[i])
        sense_in[i] = 1'b1;
      else
        sense_in[i] = float_q[i];
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_hub_strap_decode_port_power.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_hub_strap_decode_port_power;
  import hsd_pkg::*;
  logic          mclk;
  logic          rst_n;
  logic          split_mode;
  logic          pm_wr;
  logic          pm_clr;
  logic          mic_pin;
  logic          vbus_pin;
  logic [4:0]    pm_idx;
  logic [5:0]    host_dis;
  logic [5:0]    oc_inj;
  logic [5:0]    s_in;
  logic [5:0]    s_out;
  logic [5:0]    s_oe_n;
  logic [5:0]    s_pu;
  logic [5:0]    oc_n;
  logic [2:0]    ss_en;
  logic          cfg_ok;
  logic          mic;
  logic          vbus;
  logic          spi_clk;
  logic          spi_ce_n;
  hsd_pin_fn_t   pm_fn;
  hsd_pin_fn_t   pin_fn [29];
  hsd_strap_t    s_cfg;
  hsd_strap_t    s_pins;
  hsd_port_cfg_t pcfg;
  int            fail_count = 0;
  int            checks_done = 0;
  logic [5:0]    mtbl [8] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0f, 6'h3f, 6'h00, 6'h00};

  hsd_strap_power dut (.mclk(mclk), .rst_n(rst_n), .strap_pins(s_pins),
    .host_port_disable(host_dis), .split_mode(split_mode), .pinmux_wr(pm_wr),
    .pinmux_idx(pm_idx), .pinmux_fn(pm_fn), .pinmux_clear(pm_clr),
    .port_power_sense_in(s_in), .port_power_sense_out(s_out),
    .port_power_sense_oe_n(s_oe_n), .port_power_sense_pullup(s_pu),
    .split_superspeed_power_enable(ss_en), .microphone_present_pin(mic_pin),
    .upstream_power_detect_pin(vbus_pin), .port_cfg(pcfg), .overcurrent_n(oc_n),
    .config_valid(cfg_ok), .microphone_present(mic),
    .upstream_power_detect(vbus), .pin_fn(pin_fn));
  hsd_board_model board (.mclk(mclk), .strap_cfg(s_cfg), .oc_inject(oc_inj),
    .sense_out(s_out), .sense_oe_n(s_oe_n), .sense_pullup(s_pu),
    .strap_pins(s_pins), .sense_in(s_in), .spi_clk_pin(spi_clk),
    .spi_chip_enable_n_pin(spi_ce_n));

  // Clock, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_fn(input int i, input hsd_pin_fn_t e);
    checks_done++;
    if (pin_fn[i] !== e) begin
      fail_count++;
      $display("MISMATCH pin_fn[%0d] expected %0d seen %0d", i, e, pin_fn[i]);
    end
  endtask

  // Default pin table, index 0 is the first programmable pin
  function automatic hsd_pin_fn_t exp_fn(input int i);
    if (i < 5) return HSD_FN_AUDIO;
    if (i < 7) return HSD_FN_NC;
    if (i < 10) return HSD_FN_SPLIT_PWR;
    if (i < 15 || i == 25) return HSD_FN_PWR_SENSE;
    if (i == 15 || i == 28) return HSD_FN_MASTER_I2C;
    if (i == 16) return HSD_FN_MICROPHONE_PRESENT;
    if (i < 23) return HSD_FN_QSPI;
    if (i < 25) return HSD_FN_TARGET_I2C;
    if (i == 26) return HSD_FN_GPIO;
    return HSD_FN_UP_PWR_DET;
  endfunction

  // Reset long enough for the strap synchroniser to fill
  task automatic do_reset(input hsd_strap_t s);
    @(posedge mclk);
    s_cfg <= s;
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("spi_idle", 6'h01, {4'h0, spi_clk, spi_ce_n});
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic pm_write(input logic [4:0] i, input hsd_pin_fn_t f, input logic c);
    pm_wr <= 1'b1;
    pm_idx <= i;
    pm_fn <= f;
    pm_clr <= c;
    @(posedge mclk);
  endtask

  task automatic t_straps;
    for (int c = 0; c < 8; c++) begin
      do_reset('{6'h21, 6'h22 | 6'h20, 3'(c), 3'(7 - c), 3'h0, 3'(c)});
      chk("hs_disabled", 6'h20, pcfg.hs_disabled);
      chk("ss_disabled", 6'h20, pcfg.ss_disabled);
      chk("fixed_mask", mtbl[c], pcfg.fixed_mask);
      chk("charge_mask", mtbl[7 - c], pcfg.charge_mask);
      chk("config_valid", {5'h00, c == 2}, {5'h00, cfg_ok});
    end
    chk_fn(0, HSD_FN_NC);
    @(posedge mclk);
    s_cfg <= '{6'h3f, 6'h3f, 3'h5, 3'h5, 3'h0, 3'h2};
    repeat (5) @(posedge mclk);
    #1;
    chk("held_hs", 6'h20, pcfg.hs_disabled);
    $display("test straps done");
  endtask

  task automatic t_pins;
    do_reset('{6'h00, 6'h00, 3'h0, 3'h0, 3'h0, 3'h2});
    for (int i = 0; i < 29; i++) chk_fn(i, exp_fn(i));
    @(posedge mclk);
    pm_write(5'h05, HSD_FN_GPIO, 1'b0);
    pm_write(5'h1c, HSD_FN_QSPI, 1'b0);
    pm_write(5'h1d, HSD_FN_MICROPHONE_PRESENT, 1'b0);
    #1;
    chk_fn(5, HSD_FN_GPIO);
    chk_fn(28, HSD_FN_QSPI);
    chk_fn(27, HSD_FN_UP_PWR_DET);
    @(posedge mclk);
    pm_write(5'h03, HSD_FN_GPIO, 1'b1);
    pm_wr <= 1'b0;
    pm_clr <= 1'b0;
    @(posedge mclk);
    #1;
    chk_fn(3, HSD_FN_AUDIO);
    chk_fn(5, HSD_FN_NC);
    chk_fn(28, HSD_FN_MASTER_I2C);
    $display("test pins done");
  endtask

  task automatic t_power;
    do_reset('{6'h28, 6'h28, 3'h0, 3'h0, 3'h0, 3'h2});
    chk("oe_n", 6'h17, s_oe_n);
    chk("pullup", 6'h17, s_pu);
    @(posedge mclk);
    host_dis <= 6'h01;
    oc_inj <= 6'h22;
    repeat (4) @(posedge mclk);
    #1;
    chk("oe_n_host", 6'h16, s_oe_n);
    chk("out", 6'h00, s_out);
    chk("oc_n", 6'h3d, oc_n);
    @(posedge mclk);
    split_mode <= 1'b1;
    host_dis <= 6'h00;
    oc_inj <= 6'h00;
    repeat (2) @(posedge mclk);
    #1;
    chk("split_on", 6'h05, {3'h0, ss_en});
    @(posedge mclk);
    split_mode <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("split_off", 6'h00, {3'h0, ss_en});
    $display("test power done");
  endtask

  task automatic t_sense(input logic v);
    @(posedge mclk);
    mic_pin <= v;
    vbus_pin <= ~v;
    repeat (4) @(posedge mclk);
    #1;
    chk("mic", {5'h00, v}, {5'h00, mic});
    chk("vbus", {5'h00, ~v}, {5'h00, vbus});
    $display("test sense done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 135 cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    print_verdict;
  end

  initial begin
    {rst_n, split_mode, pm_wr, pm_clr, mic_pin, vbus_pin} = 6'h00;
    {pm_idx, host_dis, oc_inj} = 17'h00000;
    pm_fn = HSD_FN_NC;
    s_cfg = '0;
    t_straps;
    t_pins;
    t_power;
    t_sense(1'b1);
    t_sense(1'b0);
    print_verdict;
  end
endmodule
`default_nettype wire
